// *** src/aicp_pkg.sv ***
// constants, register map and state codes of the front-end configuration port
package aicp_pkg;
  localparam int REG_W = 8;
  localparam logic [6:0] SLAVE_ADDR = 7'h48;
  // register offsets
  localparam logic [7:0] OFS_READY = 8'h00;
  localparam logic [7:0] OFS_PROTECT = 8'h01;
  localparam logic [7:0] OFS_AMP = 8'h10;
  localparam logic [7:0] OFS_REF = 8'h11;
  localparam logic [7:0] OFS_OPSEL = 8'h12;
  // reset values
  localparam logic [7:0] RST_READY = 8'h00;
  localparam logic [7:0] RST_PROTECT = 8'h01;
  localparam logic [7:0] RST_AMP = 8'h03;
  localparam logic [7:0] RST_REF = 8'h20;
  localparam logic [7:0] RST_OPSEL = 8'h00;
  // field positions
  localparam int PROTECT_BIT = 0;
  localparam int FB_LSB = 2;
  localparam int FB_MSB = 4;
  localparam int LOAD_LSB = 0;
  localparam int LOAD_MSB = 1;
  localparam int SHORT_BIT = 7;
  localparam int OPC_LSB = 0;
  localparam int OPC_MSB = 2;
  // writable masks, reserved bits store and read as zero
  localparam logic [7:0] MASK_PROTECT = 8'h01;
  localparam logic [7:0] MASK_AMP = 8'h1f;
  localparam logic [7:0] MASK_REF = 8'hff;
  localparam logic [7:0] MASK_OPSEL = 8'h87;
  // operation codes
  localparam logic [2:0] OPC_DEEP_SLEEP = 3'h0;
  localparam logic [2:0] OPC_TWO_LEAD = 3'h1;
  localparam logic [2:0] OPC_STANDBY = 3'h2;
  localparam logic [2:0] OPC_THREE_LEAD = 3'h3;
  localparam logic [2:0] OPC_TEMP_AMP_OFF = 3'h6;
  localparam logic [2:0] OPC_TEMP_AMP_ON = 3'h7;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
  localparam int TIMEOUT_US = 25000;
  localparam int READY_DELAY_US = 10;
  localparam int READY_CYCLES = (CLK_HZ / 1_000_000) * READY_DELAY_US;
  typedef enum logic [9:0] {
    ST_IDLE = 10'b0000000001,
    ST_ADDR = 10'b0000000010,
    ST_ADDR_ACK = 10'b0000000100,
    ST_PTR = 10'b0000001000,
    ST_PTR_ACK = 10'b0000010000,
    ST_WDATA = 10'b0000100000,
    ST_WDATA_ACK = 10'b0001000000,
    ST_RDATA = 10'b0010000000,
    ST_RDATA_ACK = 10'b0100000000,
    ST_IGNORE = 10'b1000000000
  } aicp_state_e;
endpackage : aicp_pkg

// *** src/aicp_pin_sync.sv ***
// three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ns
module aicp_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  wire [W-1:0] agree = ~(s2_q ^ s3_q);
  wire [W-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);

  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end

  assign level_out = lvl_q;
endmodule : aicp_pin_sync

// *** src/aicp_config_port.sv ***
// serial configuration port with register bank, bus-stuck timeout and mode decode
`timescale 1ns/1ns
// Behaviour
// - clock line low past the stuck limit resets the serial logic
// - data held low by us past the stuck limit resets and releases it
// - after reset deep sleep: commands accepted, both amplifiers and sensor off
// - standby: current-to-voltage amp off, control amplifier on
// - three-lead: control amp, current-to-voltage amp and bias all on
// - temperature, amp off: standby enables plus sensor routed to output
// - temperature, amp on: three-lead enables plus sensor routed to output
// - two-lead: control amplifier off, internal zero bypassed
// - standard mode; zero pulls low, one releases to pull-up
// - fixed seven-bit slave address
// - ack a matching address, nack any other
// - write: pointer byte then one data byte, each acked
// - read: pointer write, repeated start, read address, byte shifted out
// - status bit 0 shows ready; data writes refused until ready
// - protection bit 0 locks amplifier and reference registers, reset locked
// - amplifier bits 4:2 select feedback resistance
// - amplifier bits 1:0 select load resistance, bits 7:5 reserved
// - register map offsets and reset values; mode register never locked
// - respond only while module enable is low
// - mode bits 2:0 select operation, bit 7 the shorting switch
module aicp_config_port #(
  parameter int TIMEOUT_TICKS = aicp_pkg::TIMEOUT_US
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic module_enable_n_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic device_ready_out,
  output logic control_amplifier_en_out,
  output logic current_to_voltage_amp_en_out,
  output logic bias_en_out,
  output logic temp_sensor_en_out,
  output logic analog_output_temp_sel_out,
  output logic zero_bypass_out,
  output logic electrode_short_switch_out,
  output logic [2:0] feedback_resistance_sel_out,
  output logic [1:0] load_resistance_sel_out,
  output logic [aicp_pkg::REG_W-1:0] reference_bias_control_out
);
  import aicp_pkg::*;

  // synchronised pins
  logic [2:0] pins_f;
  aicp_pin_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .pin_in({module_enable_n_in, sda_in, scl_in}),
    .level_out(pins_f)
  );
  wire scl_f = pins_f[0];
  wire sda_f = pins_f[1];
  wire enable_n_f = pins_f[2];

  logic scl_prev_q;
  logic sda_prev_q;
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end

  wire scl_rise = scl_f & ~scl_prev_q;
  wire scl_fall = ~scl_f & scl_prev_q;
  wire start_seen = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  wire stop_seen = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // registers
  aicp_state_e state_q;
  aicp_state_e state_d;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic drive_low_q;
  logic read_dir_q;
  logic master_ack_q;
  logic [7:0] protect_q;
  logic [7:0] amp_q;
  logic [7:0] ref_q;
  logic [7:0] opsel_q;
  logic ready_q;
  logic [7:0] ready_cnt_q;

  // internal timebase and bus-stuck watch
  logic [4:0] tick_cnt_q;
  logic [15:0] stuck_cnt_q;
  wire tick = (tick_cnt_q == 5'(TICK_CYCLES - 1));
  wire stuck_cond = ~scl_f | drive_low_q;
  wire line_change = (scl_f ^ scl_prev_q) | (sda_f ^ sda_prev_q);
  wire stuck_hit = (stuck_cnt_q >= 16'(TIMEOUT_TICKS));

  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
      tick_cnt_q <= 5'h00;
    else
      tick_cnt_q <= tick ? 5'h00 : tick_cnt_q + 5'h01;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
      stuck_cnt_q <= 16'h0000;
    else if (!stuck_cond || line_change || stuck_hit)
      stuck_cnt_q <= 16'h0000;
    else if (tick)
      stuck_cnt_q <= stuck_cnt_q + 16'h0001;

  // decode
  function automatic logic [7:0] read_reg(input logic [7:0] ofs, input logic [7:0] prot,
                                          input logic [7:0] amp, input logic [7:0] refc,
                                          input logic [7:0] ops, input logic rdy);
    case (ofs)
      OFS_READY: read_reg = {7'h00, rdy};
      OFS_PROTECT: read_reg = prot;
      OFS_AMP: read_reg = amp;
      OFS_REF: read_reg = refc;
      OFS_OPSEL: read_reg = ops;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  wire bus_abort = enable_n_f | stuck_hit;
  wire byte_done = scl_fall & (bit_cnt_q == 4'h8);
  wire addr_match = (shift_q[7:1] == SLAVE_ADDR);
  wire locked = protect_q[PROTECT_BIT];
  wire lockable = (ptr_q == OFS_AMP) | (ptr_q == OFS_REF);
  wire wr_commit = (state_q == ST_WDATA) & byte_done & ready_q;
  wire wr_allowed = wr_commit & ~(locked & lockable);
  wire [7:0] rd_byte = read_reg(ptr_q, protect_q, amp_q, ref_q, opsel_q, ready_q);
  wire [7:0] wr_byte = shift_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: state_d = ST_IDLE;
      ST_ADDR: if (byte_done) state_d = addr_match ? ST_ADDR_ACK : ST_IGNORE;
      ST_ADDR_ACK: if (scl_fall) state_d = read_dir_q ? ST_RDATA : ST_PTR;
      ST_PTR: if (byte_done) state_d = ST_PTR_ACK;
      ST_PTR_ACK: if (scl_fall) state_d = ST_WDATA;
      ST_WDATA: if (byte_done) state_d = ready_q ? ST_WDATA_ACK : ST_IGNORE;
      ST_WDATA_ACK: if (scl_fall) state_d = ST_IGNORE;
      ST_RDATA: if (byte_done) state_d = ST_RDATA_ACK;
      ST_RDATA_ACK: if (scl_fall) state_d = master_ack_q ? ST_RDATA : ST_IGNORE;
      ST_IGNORE: state_d = ST_IGNORE;
      default: state_d = ST_IDLE;
    endcase
    if (start_seen)
      state_d = ST_ADDR;
    if (stop_seen)
      state_d = ST_IDLE;
    if (bus_abort)
      state_d = ST_IDLE;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;

  // bit counter and shifter
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end
    else if (start_seen || bus_abort || (scl_fall && state_q != state_d))
    begin
      bit_cnt_q <= 4'h0;
      shift_q <= (state_d == ST_RDATA) ? rd_byte : 8'h00;
    end
    else if (scl_rise && state_q != ST_RDATA)
    begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shift_q <= {shift_q[6:0], sda_f};
    end
    else if (scl_rise)
      bit_cnt_q <= bit_cnt_q + 4'h1;
    else if (scl_fall && state_q == ST_RDATA)
      shift_q <= {shift_q[6:0], 1'b0};

  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      read_dir_q <= 1'b0;
      master_ack_q <= 1'b0;
      ptr_q <= 8'h00;
    end
    else
    begin
      if (state_q == ST_ADDR && byte_done)
        read_dir_q <= shift_q[0];
      if (state_q == ST_RDATA_ACK && scl_rise)
        master_ack_q <= ~sda_f;
      if (state_q == ST_PTR && byte_done)
        ptr_q <= shift_q;
    end

  // data line: only ever pulled low, never driven high
  wire drive_d = (state_d == ST_ADDR_ACK) | (state_d == ST_PTR_ACK) | (state_d == ST_WDATA_ACK)
               | ((state_d == ST_RDATA) & ~(scl_fall ? (state_q == ST_RDATA ? shift_q[6] : rd_byte[7])
                                                      : shift_q[7]));
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
      drive_low_q <= 1'b0;
    else if (bus_abort || start_seen || stop_seen)
      drive_low_q <= 1'b0;
    else if (scl_fall)
      drive_low_q <= drive_d;
  assign sda_out = 1'b0;
  assign sda_oe_out = drive_low_q;

  // register bank
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      protect_q <= RST_PROTECT;
      amp_q <= RST_AMP;
      ref_q <= RST_REF;
      opsel_q <= RST_OPSEL;
    end
    else if (wr_allowed)
    begin
      if (ptr_q == OFS_PROTECT)
        protect_q <= wr_byte & MASK_PROTECT;
      if (ptr_q == OFS_AMP)
        amp_q <= wr_byte & MASK_AMP;
      if (ptr_q == OFS_REF)
        ref_q <= wr_byte & MASK_REF;
      if (ptr_q == OFS_OPSEL)
        opsel_q <= wr_byte & MASK_OPSEL;
    end

  // power-on readiness
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      ready_cnt_q <= 8'h00;
      ready_q <= RST_READY[0];
    end
    else if (!ready_q)
    begin
      ready_cnt_q <= ready_cnt_q + 8'h01;
      ready_q <= (ready_cnt_q == 8'(READY_CYCLES - 1));
    end
  assign device_ready_out = ready_q;

  // analog enables from the operation code
  wire [2:0] opc = opsel_q[OPC_MSB:OPC_LSB];
  wire op_three = (opc == OPC_THREE_LEAD) | (opc == OPC_TEMP_AMP_ON);
  wire op_standby = (opc == OPC_STANDBY) | (opc == OPC_TEMP_AMP_OFF);
  wire op_temp = (opc == OPC_TEMP_AMP_OFF) | (opc == OPC_TEMP_AMP_ON);
  wire op_two = (opc == OPC_TWO_LEAD);
  assign control_amplifier_en_out = op_three | op_standby;
  assign current_to_voltage_amp_en_out = op_three | op_two;
  assign bias_en_out = op_three;
  assign temp_sensor_en_out = op_temp;
  assign analog_output_temp_sel_out = op_temp;
  assign zero_bypass_out = op_two;
  assign electrode_short_switch_out = opsel_q[SHORT_BIT];
  assign feedback_resistance_sel_out = amp_q[FB_MSB:FB_LSB];
  assign load_resistance_sel_out = amp_q[LOAD_MSB:LOAD_LSB];
  assign reference_bias_control_out = ref_q;

  // checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_addr_matched;
    (state_q == ST_ADDR) && byte_done && addr_match && !bus_abort && !start_seen && !stop_seen;
  endsequence
  sequence s_addr_missed;
    (state_q == ST_ADDR) && byte_done && !addr_match;
  endsequence

  addr_ack_drive_a: assert property (s_addr_matched |=> sda_oe_out && state_q == ST_ADDR_ACK)
    else $error("matching address not acked");
  addr_nack_release_a: assert property (s_addr_missed |=> !sda_oe_out [*2])
    else $error("foreign address pulled data low");
  enable_gate_a: assert property (enable_n_f |=> !sda_oe_out && state_q == ST_IDLE)
    else $error("bus answered while disabled");
  stuck_release_a: assert property (stuck_hit |=> !sda_oe_out && state_q == ST_IDLE)
    else $error("stuck bus did not reset serial logic");
  stuck_bound_a: assert property (stuck_cnt_q <= 16'(TIMEOUT_TICKS))
    else $error("stuck timer overran its limit");
  sleep_off_a: assert property (opc == OPC_DEEP_SLEEP |-> !control_amplifier_en_out
      && !current_to_voltage_amp_en_out && !temp_sensor_en_out)
    else $error("deep sleep left an amplifier on");
  standby_en_a: assert property (opc == OPC_STANDBY |-> control_amplifier_en_out
      && !current_to_voltage_amp_en_out)
    else $error("standby enables wrong");
  three_lead_a: assert property (opc == OPC_THREE_LEAD |-> control_amplifier_en_out
      && current_to_voltage_amp_en_out && bias_en_out && !temp_sensor_en_out)
    else $error("three-lead enables wrong");
  temp_off_a: assert property (opc == OPC_TEMP_AMP_OFF |-> control_amplifier_en_out
      && !current_to_voltage_amp_en_out && analog_output_temp_sel_out)
    else $error("temperature amp-off enables wrong");
  temp_on_a: assert property (opc == OPC_TEMP_AMP_ON |-> bias_en_out
      && current_to_voltage_amp_en_out && analog_output_temp_sel_out)
    else $error("temperature amp-on enables wrong");
  two_lead_a: assert property (opc == OPC_TWO_LEAD |-> !control_amplifier_en_out
      && zero_bypass_out)
    else $error("two-lead enables wrong");
  lock_hold_a: assert property (locked && ptr_q == OFS_AMP |=> $stable(amp_q))
    else $error("locked amplifier register changed");
  opsel_write_a: assert property (wr_commit && ptr_q == OFS_OPSEL
      |=> opsel_q == $past(wr_byte & MASK_OPSEL))
    else $error("mode register write lost");
  not_ready_a: assert property (!ready_q |=> $stable(protect_q) && $stable(opsel_q))
    else $error("register changed before ready");
  ready_time_a: assert property ($rose(ready_q) |-> ready_cnt_q == 8'(READY_CYCLES))
    else $error("ready raised at the wrong time");

  // write path: data byte acked, ack dropped again on the following clock fall
  sequence s_wdata_taken;
    (state_q == ST_WDATA) && byte_done && ready_q && !bus_abort && !start_seen && !stop_seen;
  endsequence
  sequence s_ack_done;
    (state_q == ST_WDATA_ACK) && scl_fall && !bus_abort && !start_seen && !stop_seen;
  endsequence
  wdata_ack_a: assert property (s_wdata_taken |=> sda_oe_out && state_q == ST_WDATA_ACK)
    else $error("data byte not acked");
  ack_release_a: assert property (s_ack_done |=> !sda_oe_out && state_q == ST_IGNORE)
    else $error("data ack not released");
  lock_ref_a: assert property (locked && ptr_q == OFS_REF |=> $stable(ref_q))
    else $error("locked reference register changed");
  rd_load_a: assert property ((state_q == ST_ADDR_ACK) && scl_fall && read_dir_q && !bus_abort
      && !start_seen && !stop_seen |=> shift_q == $past(rd_byte))
    else $error("read byte not loaded for shifting");
endmodule : aicp_config_port

// *** tb/aicp_i2c_master.sv ***
// bus master model: open-drain clock and data, module enable
`timescale 1ns/1ns
module aicp_i2c_master (
  input wire logic clk_sys_in,
  input wire logic sda_in,
  output logic scl_oe_out,
  output logic sda_oe_out,
  output logic module_enable_n_out
);
  logic bad_en;
  logic ack_v;
  logic [7:0] byte_v;
  event ack_ev;
  event byte_ev;
  initial
  begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
    module_enable_n_out = 1'b1;
    bad_en = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : wt
  // data moves late in the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    wt(6);
    sda_oe_out = ~b;
    wt(2);
    scl_oe_out = 1'b0;
    wt(4);
    s = sda_in;
    wt(4);
    scl_oe_out = 1'b1;
  endtask : bit_io
  // also serves as repeated start
  task automatic start();
    if (module_enable_n_out)
    begin
      module_enable_n_out = bad_en;
      wt(8);
    end
    sda_oe_out = 1'b0;
    wt(8);
    scl_oe_out = 1'b0;
    wt(8);
    sda_oe_out = 1'b1;
    wt(8);
    scl_oe_out = 1'b1;
  endtask : start
  task automatic stop();
    wt(6);
    sda_oe_out = 1'b1;
    wt(2);
    scl_oe_out = 1'b0;
    wt(8);
    sda_oe_out = 1'b0;
    wt(8);
    module_enable_n_out = 1'b1;
  endtask : stop
  task automatic send_bits(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
  endtask : send_bits
  task automatic wbyte(input logic [7:0] b);
    send_bits(b);
    bit_io(1'b1, ack_v);
    ->ack_ev;
  endtask : wbyte
  task automatic rbyte(input logic m_ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, byte_v[i]);
    bit_io(m_ack, s);
    ->byte_ev;
  endtask : rbyte
endmodule : aicp_i2c_master

// *** tb/aicp_config_port_tb.sv ***
// self-checking bench of the configuration port
`timescale 1ns/1ns
module aicp_config_port_tb;
  import aicp_pkg::*;
  logic clk_sys_in;
  logic rstn_in;
  logic m_scl_oe, m_sda_oe, en_n, d_oe, d_out, rdy;
  logic ca, cva, bias, ts, asel, zb, sh;
  logic [2:0] fb;
  logic [1:0] ld;
  logic [7:0] refo, d;
  logic [31:0] r;
  wire scl_w = ~m_scl_oe;
  wire sda_w = ~(m_sda_oe | (d_oe & ~d_out));
  int err_total = 0;
  int num_checks = 0;
  logic q_ack[$];
  logic [7:0] q_byte[$];
  logic [7:0] ofs[5] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12};
  logic [7:0] rv[5] = '{8'h01, 8'h01, 8'h03, 8'h20, 8'h00};
  logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  aicp_i2c_master m (.clk_sys_in(clk_sys_in), .sda_in(sda_w), .scl_oe_out(m_scl_oe),
    .sda_oe_out(m_sda_oe), .module_enable_n_out(en_n));
  aicp_config_port #(.TIMEOUT_TICKS(50)) DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .scl_in(scl_w), .sda_in(sda_w), .module_enable_n_in(en_n), .sda_out(d_out),
    .sda_oe_out(d_oe), .device_ready_out(rdy), .control_amplifier_en_out(ca),
    .current_to_voltage_amp_en_out(cva), .bias_en_out(bias), .temp_sensor_en_out(ts),
    .analog_output_temp_sel_out(asel), .zero_bypass_out(zb),
    .electrode_short_switch_out(sh), .feedback_resistance_sel_out(fb),
    .load_resistance_sel_out(ld), .reference_bias_control_out(refo));
  always #25 clk_sys_in = ~clk_sys_in;
  task automatic end_sim();
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic cmp_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_byte
  always @(m.ack_ev) cmp_bit("ack", q_ack.size() ? q_ack.pop_front() : 1'bx, m.ack_v);
  always @(m.byte_ev) cmp_byte("read", q_byte.size() ? q_byte.pop_front() : 8'hxx, m.byte_v);
  // ea holds the expected ack levels of address, pointer and data
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dv, input logic [2:0] ea);
    for (int i = 2; i >= 0; i--) q_ack.push_back(ea[i]);
    m.start();
    m.wbyte({SLAVE_ADDR, 1'b0});
    m.wbyte(ptr);
    m.wbyte(dv);
    m.stop();
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
    for (int i = 0; i < 3; i++) q_ack.push_back(1'b0);
    q_byte.push_back(e);
    m.start();
    m.wbyte({SLAVE_ADDR, 1'b0});
    m.wbyte(ptr);
    m.start();
    m.wbyte({SLAVE_ADDR, 1'b1});
    m.rbyte(1'b1);
    m.stop();
  endtask : rd
  task automatic addr_only(input logic [7:0] a);
    q_ack.push_back(1'b1);
    m.start();
    m.wbyte(a);
    m.stop();
  endtask : addr_only
  task automatic chk_mode(input logic [7:0] v);
    logic [2:0] c;
    c = v[2:0];
    cmp_byte("mode outputs", {1'b0, c[1], (c == 3'h1) | (c[1] & c[0]), c[1] & c[0],
      c[2] & c[1], c[2] & c[1], c == 3'h1, v[7]}, {1'b0, ca, cva, bias, ts, asel, zb, sh});
  endtask : chk_mode
  initial
  begin
    #3_000_000;
    err_total++;
    end_sim();
  end
  initial
  begin
    clk_sys_in = 1'b0;
    rstn_in = 1'b0;
    void'($urandom(32'h36da));
    repeat (8) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    chk_mode(8'h00);
    cmp_byte("amp outputs", 8'h03, {3'b000, fb, ld});
    cmp_byte("reference", 8'h20, refo);
    repeat (150) @(negedge clk_sys_in);
    cmp_bit("ready early", 1'b0, rdy);
    for (int n = 0; n < 100 && rdy !== 1'b1; n++) @(negedge clk_sys_in);
    cmp_bit("ready", 1'b1, rdy);
    if (rdy !== 1'b1)
      end_sim();
    for (int i = 0; i < 5; i++) rd(ofs[i], rv[i]);
    r = $urandom;
    addr_only({r[6:0] == SLAVE_ADDR ? 7'h49 : r[6:0], 1'b0});
    m.bad_en = 1'b1;
    addr_only({SLAVE_ADDR, 1'b0});
    m.bad_en = 1'b0;
    wr(8'h10, 8'h1c, 3'b000);
    rd(8'h10, 8'h03);
    wr(8'h01, 8'h00, 3'b000);
    r = $urandom;
    d = {3'b000, r[4:0]};
    wr(8'h10, d, 3'b000);
    cmp_byte("amp outputs", d, {3'b000, fb, ld});
    rd(8'h10, d);
    // external feedback resistor fitted: software selects the external setting
    wr(8'h10, 8'h03, 3'b000);
    cmp_byte("amp outputs", 8'h03, {3'b000, fb, ld});
    r = $urandom;
    wr(8'h11, r[7:0], 3'b000);
    cmp_byte("reference", r[7:0], refo);
    rd(8'h11, r[7:0]);
    wr(8'h05, 8'h5a, 3'b000);
    rd(8'h05, 8'h00);
    wr(8'h01, 8'h01, 3'b000);
    foreach (codes[i])
    begin
      r = $urandom;
      d = {r[0], 4'h0, codes[i]};
      wr(8'h12, d, 3'b000);
      chk_mode(d);
    end
    // clock held low while the device drives its ack
    m.start();
    m.send_bits({SLAVE_ADDR, 1'b0});
    m.wt(20);
    cmp_bit("ack drive", 1'b1, d_oe);
    m.wt(900);
    cmp_bit("early release", 1'b1, d_oe);
    m.wt(300);
    cmp_bit("stuck release", 1'b0, d_oe);
    m.stop();
    rd(8'h12, d);
    m.wt(20);
    end_sim();
  end
endmodule : aicp_config_port_tb
